// >>> hdl/rgiu_params.svh
// rgiu_params.svh: offsets, field positions, reset values, timing figures
// assumes: included by bare name; times in microseconds, clock in MHz
`ifndef RGIU_PARAMS_SVH
`define RGIU_PARAMS_SVH

`define RGIU_CLK_MHZ 25

// register offsets on the 2-bit register port
`define RGIU_OFS_CTRL 2'h0
`define RGIU_OFS_STATUS 2'h1
`define RGIU_OFS_ACCESS 2'h2
`define RGIU_OFS_RESTART 2'h3

// control register fields
`define RGIU_CTRL_SW_INHIBIT 0
`define RGIU_CTRL_PERM_EN 1
`define RGIU_CTRL_FREQ_EN 2
`define RGIU_CTRL_LIMIT_LOW 3
`define RGIU_CTRL_FILTER_EN 4
`define RGIU_CTRL_REDUNDANT 5
`define RGIU_CTRL_RESET 6'h06

// status register fields
`define RGIU_STAT_ENABLED 0
`define RGIU_STAT_LINES 1
`define RGIU_STAT_SUBST 4
`define RGIU_STAT_SW_INHIBIT 5
`define RGIU_STAT_FREQ_FAULT 6
`define RGIU_STAT_PERM_FAULT 7

// times
`define RGIU_T_HOLD_US 1630
`define RGIU_T_QUIET_US 100
`define RGIU_T_FILTER_US 1630
`define RGIU_T_INTERVAL_US 3200000
`define RGIU_T_SEC_US 6
`define RGIU_T_TER_US 12
`define RGIU_T_LAST_US 18
`define RGIU_T_WIN_US 2

// interrupt count limits
`define RGIU_LIMIT_HIGH 160
`define RGIU_LIMIT_LOW 32

`endif

// >>> hdl/rgiu_pkg.sv
// rgiu_pkg: types shared by the group interrupt unit
// assumes: constants live in rgiu_params.svh
package rgiu_pkg;

    typedef enum logic [1:0] {
        ROLE_NONE = 2'h0,
        ROLE_PRI = 2'h1,
        ROLE_SEC = 2'h3,
        ROLE_TER = 2'h2
    } rgiu_role_t;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'h0,
        ACC_RUN = 2'h1,
        ACC_DONE = 2'h3
    } rgiu_acc_t;

    typedef enum logic [1:0] {
        REGK_NONE = 2'h0,
        REGK_NORMAL = 2'h1,
        REGK_MC_DOUBLE = 2'h2,
        REGK_MC_NONE = 2'h3
    } rgiu_regk_t;

    typedef struct packed {
        logic none;
        logic one;
        logic more;
    } rgiu_check_t;

    typedef struct packed {
        logic req;
        logic rd;
        logic [2:0] addr;
    } rgiu_gacc_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rgiu_bus_t;

endpackage : rgiu_pkg

// >>> hdl/rgiu_top.sv
// rgiu_top: group interrupt gating and redundant group module answers
// assumes: all inputs synchronous to clk except ext_int_lines
//
// What this block does
// - two-flop synchronise all four extension interrupt lines before fan-out.
// - forward interrupt only in control and enable conditions met; frequency block stops only new ones.
// - no jumper responsibility permanently blocks the group interrupt.
// - reading group module byte 0 forces interrupt removal at once.
// - re-enable only after 1.63 ms and, with permanent blocking on, line quiet 100 us.
// - permanent interrupt forwarded once, then suppressed until it drops.
// - count forwarded interrupts, block beyond limit 160 or 32 per 3.2 s.
// - software restart write shortens the frequency interval.
// - permanent and frequency blocking each enabled independently.
// - this unit counts its own alarms even when peers share them.
// - optional digital filter delays the group interrupt by 1.63 ms.
// - address bits two and one pick alarm group; bit zero ignored.
// - secondary and tertiary roles follow from primary jumper.
// - drive group module select in step with all peer units.
// - primary answers at once, needing correct check when redundant.
// - secondary answers at 6 us, tertiary at 12 us.
// - primary gives zero data, bus check, forced ready at 18 us.
// - windows never overlap; ready window narrower than data window.
// - jumper chooses real data or zero for substitute answers.
// - register access gives one check; multicast gives double or none.
// - comparator results qualified by select and response windows.
// - status reports whether the group interrupt is enabled.
`timescale 1ns/100ps
`include "rgiu_params.svh"

module rgiu_top #(
    parameter int unsigned HOLD_CYC = `RGIU_T_HOLD_US * `RGIU_CLK_MHZ,
    parameter int unsigned FILT_CYC = `RGIU_T_FILTER_US * `RGIU_CLK_MHZ,
    parameter int unsigned INTV_CYC = `RGIU_T_INTERVAL_US * `RGIU_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire rgiu_pkg::rgiu_bus_t bus,
    output logic [7:0] rdata,
    input wire logic [3:0] ext_int_lines,
    input wire logic in_control,
    input wire logic [2:0] jumper_primary,
    input wire logic jumper_subst_data,
    input wire rgiu_pkg::rgiu_gacc_t gacc,
    input wire logic [7:0] gim_data,
    input wire rgiu_pkg::rgiu_check_t cmp,
    input wire rgiu_pkg::rgiu_regk_t reg_kind,
    output logic [3:0] ext_int_sync,
    output logic group_interrupt,
    output logic gim_sel,
    output logic [7:0] cpu_data,
    output logic cpu_ready,
    output rgiu_pkg::rgiu_check_t check_out
);

    localparam int unsigned QUIET_CYC = `RGIU_T_QUIET_US * `RGIU_CLK_MHZ;
    localparam logic [15:0] SEC_CYC = 16'(`RGIU_T_SEC_US * `RGIU_CLK_MHZ);
    localparam logic [15:0] TER_CYC = 16'(`RGIU_T_TER_US * `RGIU_CLK_MHZ);
    localparam logic [15:0] LAST_CYC = 16'(`RGIU_T_LAST_US * `RGIU_CLK_MHZ);
    localparam logic [15:0] WIN_CYC = 16'(`RGIU_T_WIN_US * `RGIU_CLK_MHZ);
    localparam logic [7:0] LIM_HIGH = 8'(`RGIU_LIMIT_HIGH);
    localparam logic [7:0] LIM_LOW = 8'(`RGIU_LIMIT_LOW);

    // role of this unit for an alarm group
    function automatic rgiu_pkg::rgiu_role_t role_of(
        input logic [2:0] jp,
        input logic [1:0] g
    );
        logic [1:0] p;
        logic [2:0] d;
        p = jp[0] ? 2'h0 : (jp[1] ? 2'h1 : 2'h2);
        d = {1'b0, g} + 3'h3 - {1'b0, p};
        if (d >= 3'h3)
        begin
            d = d - 3'h3;
        end
        if (g == 2'h3 || jp == 3'h0)
        begin
            role_of = rgiu_pkg::ROLE_NONE;
        end
        else if (jp[g])
        begin
            role_of = rgiu_pkg::ROLE_PRI;
        end
        else if (d == 3'h1)
        begin
            role_of = rgiu_pkg::ROLE_SEC;
        end
        else
        begin
            role_of = rgiu_pkg::ROLE_TER;
        end
    endfunction : role_of

    // open window of length WIN_CYC starting at start, trimmed by trim each side
    function automatic logic in_win(
        input logic [15:0] cnt,
        input logic [15:0] start,
        input logic [15:0] trim
    );
        in_win = cnt >= start + trim && cnt < start + WIN_CYC - trim;
    endfunction : in_win

    ////////////////////////////////////////////////////////////////////////
    // control register and interrupt line synchronisers

    logic [5:0] ctrl_reg;
    logic [3:0] sync1_reg;
    logic line_prev_reg;
    logic line;
    logic restart;

    assign line = ext_int_sync[0];
    assign restart = bus.wr && bus.addr == `RGIU_OFS_RESTART;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= `RGIU_CTRL_RESET;
        else if (ce && bus.wr && bus.addr == `RGIU_OFS_CTRL)
            ctrl_reg <= bus.wdata[5:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= 4'h0;
            ext_int_sync <= 4'h0;
            line_prev_reg <= 1'b0;
        end
        else if (ce)
        begin
            sync1_reg <= ext_int_lines;
            ext_int_sync <= sync1_reg;
            line_prev_reg <= line;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // digital filter, forced removal and hold-off

    logic [31:0] filt_cnt_reg;
    logic [31:0] hold_cnt_reg;
    logic [31:0] quiet_cnt_reg;
    logic hold_reg;
    logic filt_done;
    logic filt_busy;
    logic byte0_rd;
    logic hold_time_done;
    logic quiet_done;
    logic perm_fault;
    rgiu_pkg::rgiu_acc_t acc_state;

    assign filt_done = filt_cnt_reg == FILT_CYC;
    assign filt_busy = ctrl_reg[`RGIU_CTRL_FILTER_EN] && line && !filt_done;
    assign byte0_rd = gacc.req && gacc.rd && gacc.addr == 3'h0 &&
        acc_state == rgiu_pkg::ACC_IDLE;
    assign hold_time_done = hold_cnt_reg == HOLD_CYC;
    assign quiet_done = quiet_cnt_reg == QUIET_CYC;
    assign perm_fault = ctrl_reg[`RGIU_CTRL_PERM_EN] && hold_reg &&
        hold_time_done && line;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            filt_cnt_reg <= 32'h0;
        else if (ce)
        begin
            if (!line)
                filt_cnt_reg <= 32'h0;
            else if (!filt_done)
                filt_cnt_reg <= filt_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hold_reg <= 1'b0;
            hold_cnt_reg <= 32'h0;
            quiet_cnt_reg <= 32'h0;
        end
        else if (ce)
        begin
            if (byte0_rd)
            begin
                hold_reg <= 1'b1;
                hold_cnt_reg <= 32'h0;
                quiet_cnt_reg <= 32'h0;
            end
            else
            begin
                if (!hold_time_done)
                    hold_cnt_reg <= hold_cnt_reg + 32'h1;
                if (line)
                    quiet_cnt_reg <= 32'h0;
                else if (!quiet_done)
                    quiet_cnt_reg <= quiet_cnt_reg + 32'h1;
                // with permanent blocking off the quiet time is waived
                if (hold_time_done && (quiet_done ||
                    !ctrl_reg[`RGIU_CTRL_PERM_EN]))
                    hold_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frequency monitor and group interrupt output

    logic [31:0] intv_cnt_reg;
    logic [7:0] freq_cnt_reg;
    logic [7:0] limit;
    logic freq_block;
    logic enabled;
    logic responsible;
    logic line_q;
    logic gi_next;

    assign limit = ctrl_reg[`RGIU_CTRL_LIMIT_LOW] ? LIM_LOW : LIM_HIGH;
    assign freq_block = ctrl_reg[`RGIU_CTRL_FREQ_EN] &&
        freq_cnt_reg == limit;
    assign enabled = !perm_fault && !freq_block && !hold_reg && !filt_busy &&
        !ctrl_reg[`RGIU_CTRL_SW_INHIBIT] && in_control;
    assign responsible = |jumper_primary;
    assign line_q = ctrl_reg[`RGIU_CTRL_FILTER_EN] ? filt_done : line;
    // a new interrupt needs room under the limit; a running one is kept
    assign gi_next = responsible && in_control && line_q && !byte0_rd &&
        !hold_reg && !perm_fault && !filt_busy &&
        !ctrl_reg[`RGIU_CTRL_SW_INHIBIT] &&
        (group_interrupt || !freq_block);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            group_interrupt <= 1'b0;
        else if (ce)
            group_interrupt <= gi_next;
    end

    // each unit counts its own forwarded edges, shared alarms included
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            intv_cnt_reg <= 32'h0;
            freq_cnt_reg <= 8'h0;
        end
        else if (ce)
        begin
            if (restart || intv_cnt_reg == INTV_CYC - 32'h1)
            begin
                intv_cnt_reg <= 32'h0;
                freq_cnt_reg <= {7'h0, gi_next && !group_interrupt};
            end
            else
            begin
                intv_cnt_reg <= intv_cnt_reg + 32'h1;
                if (gi_next && !group_interrupt && freq_cnt_reg != limit)
                    freq_cnt_reg <= freq_cnt_reg + 8'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // group module access windows

    rgiu_pkg::rgiu_role_t role_reg;
    rgiu_pkg::rgiu_role_t last_role_reg;
    logic [15:0] acc_cnt_reg;
    logic pri_ok;
    logic data_win;
    logic rdy_win;
    logic zero_data;
    logic [7:0] data_next;
    rgiu_pkg::rgiu_check_t chk_next;

    assign pri_ok = role_reg == rgiu_pkg::ROLE_PRI &&
        (!ctrl_reg[`RGIU_CTRL_REDUNDANT] || cmp.one);

    always_comb
    begin
        data_win = 1'b0;
        rdy_win = 1'b0;
        zero_data = 1'b0;
        unique case (role_reg)
            rgiu_pkg::ROLE_PRI:
            begin
                if (pri_ok)
                begin
                    data_win = 1'b1;
                    rdy_win = acc_cnt_reg >= 16'h1;
                end
                else
                begin
                    data_win = in_win(acc_cnt_reg, LAST_CYC, 16'h0);
                    rdy_win = in_win(acc_cnt_reg, LAST_CYC, 16'h1);
                    zero_data = 1'b1;
                end
            end
            rgiu_pkg::ROLE_SEC:
            begin
                data_win = in_win(acc_cnt_reg, SEC_CYC, 16'h0);
                rdy_win = in_win(acc_cnt_reg, SEC_CYC, 16'h1);
                zero_data = !jumper_subst_data;
            end
            rgiu_pkg::ROLE_TER:
            begin
                data_win = in_win(acc_cnt_reg, TER_CYC, 16'h0);
                rdy_win = in_win(acc_cnt_reg, TER_CYC, 16'h1);
                zero_data = !jumper_subst_data;
            end
            rgiu_pkg::ROLE_NONE:
            begin
                data_win = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        data_next = 8'h0;
        chk_next = '0;
        if (acc_state == rgiu_pkg::ACC_DONE && gacc.req)
        begin
            data_next = cpu_data;
            chk_next = check_out;
        end
        else if (acc_state == rgiu_pkg::ACC_RUN && gacc.req && data_win)
        begin
            data_next = zero_data ? 8'h0 : gim_data;
            chk_next = cmp;
        end
        else if (acc_state == rgiu_pkg::ACC_IDLE)
        begin
            unique case (reg_kind)
                rgiu_pkg::REGK_NORMAL: chk_next.one = 1'b1;
                rgiu_pkg::REGK_MC_DOUBLE: chk_next.more = 1'b1;
                rgiu_pkg::REGK_MC_NONE: chk_next = '0;
                rgiu_pkg::REGK_NONE: chk_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_state <= rgiu_pkg::ACC_IDLE;
            acc_cnt_reg <= 16'h0;
            role_reg <= rgiu_pkg::ROLE_NONE;
        end
        else if (ce)
        begin
            unique case (acc_state)
                rgiu_pkg::ACC_IDLE:
                begin
                    acc_cnt_reg <= 16'h0;
                    if (gacc.req)
                    begin
                        acc_state <= rgiu_pkg::ACC_RUN;
                        role_reg <= role_of(jumper_primary,
                            gacc.addr[2:1]);
                    end
                end
                rgiu_pkg::ACC_RUN:
                begin
                    if (!gacc.req)
                        acc_state <= rgiu_pkg::ACC_IDLE;
                    else if (rdy_win)
                        acc_state <= rgiu_pkg::ACC_DONE;
                    if (acc_cnt_reg != LAST_CYC + WIN_CYC)
                        acc_cnt_reg <= acc_cnt_reg + 16'h1;
                end
                rgiu_pkg::ACC_DONE:
                begin
                    if (!gacc.req)
                        acc_state <= rgiu_pkg::ACC_IDLE;
                end
                default:
                begin
                    acc_state <= rgiu_pkg::ACC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_data <= 8'h0;
            cpu_ready <= 1'b0;
            check_out <= '0;
            gim_sel <= 1'b0;
            last_role_reg <= rgiu_pkg::ROLE_NONE;
        end
        else if (ce)
        begin
            cpu_data <= data_next;
            cpu_ready <= gacc.req && (acc_state == rgiu_pkg::ACC_DONE ||
                (acc_state == rgiu_pkg::ACC_RUN && rdy_win));
            check_out <= chk_next;
            gim_sel <= gacc.req && responsible;
            if (acc_state == rgiu_pkg::ACC_RUN && gacc.req && rdy_win)
                last_role_reg <= role_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h0;
        else if (ce)
        begin
            rdata <= 8'h0;
            if (bus.rd)
            begin
                unique case (bus.addr)
                    `RGIU_OFS_CTRL: rdata <= {2'h0, ctrl_reg};
                    `RGIU_OFS_STATUS: rdata <= {perm_fault, freq_block,
                        ctrl_reg[`RGIU_CTRL_SW_INHIBIT], !jumper_subst_data,
                        ext_int_sync[2:0], enabled};
                    `RGIU_OFS_ACCESS: rdata <= {6'h0, last_role_reg};
                    `RGIU_OFS_RESTART: rdata <= 8'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst || !ce);

    logic [31:0] since_b0_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            since_b0_reg <= 32'hffffffff;
        else if (ce && byte0_rd)
            since_b0_reg <= 32'h0;
        else if (ce && since_b0_reg != 32'hffffffff)
            since_b0_reg <= since_b0_reg + 32'h1;
    end

    sequence s_pri_start;
        acc_state == rgiu_pkg::ACC_IDLE && gacc.req &&
        role_of(jumper_primary, gacc.addr[2:1]) == rgiu_pkg::ROLE_PRI &&
        !ctrl_reg[`RGIU_CTRL_REDUNDANT];
    endsequence

    sequence s_held;
        gacc.req [*3];
    endsequence

    a_sync_two_stage: assert property (!$past(rst, 2) && $past(ce, 1) &&
        $past(ce, 2) |-> ext_int_sync == $past(ext_int_lines, 2))
        else $error("interrupt lines not synchronised in two stages");
    a_gi_needs_ctrl: assert property (group_interrupt |-> $past(in_control))
        else $error("group interrupt without control");
    a_gi_no_resp: assert property ($past(jumper_primary) == 3'h0 |->
        !group_interrupt)
        else $error("group interrupt from unit without responsibility");
    a_byte0_drop: assert property (byte0_rd |=> !group_interrupt [*2])
        else $error("group interrupt not removed on byte 0 read");
    a_holdoff_min: assert property ($rose(group_interrupt) |->
        since_b0_reg > HOLD_CYC)
        else $error("group interrupt re-enabled too early");
    a_freq_limit: assert property ($rose(group_interrupt) &&
        ctrl_reg[`RGIU_CTRL_FREQ_EN] |-> $past(freq_cnt_reg) < limit)
        else $error("group interrupt beyond frequency limit");
    a_restart_clears: assert property (restart |=> freq_cnt_reg <= 8'h1)
        else $error("restart did not clear frequency count");
    a_pri_at_once: assert property (s_pri_start ##0 s_held |=>
        cpu_ready)
        else $error("primary answer not immediate");
    a_sec_window: assert property ($rose(cpu_ready) &&
        role_reg == rgiu_pkg::ROLE_SEC |-> acc_cnt_reg == SEC_CYC + 16'h2)
        else $error("secondary ready at wrong time");
    a_ter_window: assert property ($rose(cpu_ready) &&
        role_reg == rgiu_pkg::ROLE_TER |-> acc_cnt_reg == TER_CYC + 16'h2)
        else $error("tertiary ready at wrong time");
    a_last_resort: assert property ($rose(cpu_ready) && !$past(pri_ok) &&
        role_reg == rgiu_pkg::ROLE_PRI |-> cpu_data == 8'h0 &&
        acc_cnt_reg == LAST_CYC + 16'h2)
        else $error("last resort answer wrong");
    a_ready_in_data: assert property ($rose(cpu_ready) |-> $past(data_win))
        else $error("ready outside data window");
    a_reg_double: assert property (acc_state == rgiu_pkg::ACC_IDLE &&
        reg_kind == rgiu_pkg::REGK_MC_DOUBLE |=> check_out.more)
        else $error("multicast double check missing");

endmodule : rgiu_top

// >>> verif/rgiu_gim_model.sv
// rgiu_gim_model: behavioural group interrupt module on the far side
// assumes: selected through gim_sel, driven by the bench's raise request
`timescale 1ns/100ps
module rgiu_gim_model #(
    parameter int unsigned OFF_CYC = 25
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic raise,
    input wire logic sel,
    input wire rgiu_pkg::rgiu_gacc_t gacc,
    input wire logic [7:0] pat,
    output logic int_line,
    output logic [7:0] data
);
    logic [7:0] off_reg;
    logic [7:0] last_reg;
    // unselected data lines float: show the inverse of the last value
    assign data = sel ? pat : ~last_reg;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            int_line <= 1'b0;
            off_reg <= 8'h00;
            last_reg <= 8'h00;
        end
        else
        begin
            if (sel && gacc.rd && gacc.addr == 3'h0)
            begin
                int_line <= 1'b0;
                off_reg <= 8'(OFF_CYC);
            end
            else if (off_reg != 8'h00)
                off_reg <= off_reg - 8'h01;
            else if (raise)
                int_line <= 1'b1;
            if (sel)
                last_reg <= pat;
        end
    end
endmodule : rgiu_gim_model

// >>> verif/tb_redundant_group_interrupt_unit.sv
// tb_redundant_group_interrupt_unit: self-checking bench for rgiu_top
// assumes: rgiu_gim_model drives line 0 and the group module data
`timescale 1ns/100ps
module tb_redundant_group_interrupt_unit;
    logic clk = 1'b0;
    logic rst = 1'b1;
    rgiu_pkg::rgiu_bus_t bus = '0;
    rgiu_pkg::rgiu_gacc_t gacc = '0;
    logic [7:0] rdata, pat = 8'h00, cpu_data, gim_data;
    logic [3:0] isync;
    logic [2:0] hl = 3'h0, jp = 3'h0;
    logic in_ctl = 1'b1, subst = 1'b0, raise = 1'b0;
    logic gim_int, gi, gsel, cpu_ready;
    logic [2:0] cm = 3'b010;
    rgiu_pkg::rgiu_check_t cko;
    rgiu_pkg::rgiu_regk_t rk = rgiu_pkg::REGK_NONE;
    integer seed = 86194, errors = 0, n_checks = 0;
    always #20 clk = ~clk;
    rgiu_top #(.HOLD_CYC(40), .FILT_CYC(20), .INTV_CYC(500)) u_dut (
        .clk(clk), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
        .ext_int_lines({hl, gim_int}), .in_control(in_ctl),
        .jumper_primary(jp), .jumper_subst_data(subst), .gacc(gacc),
        .gim_data(gim_data), .cmp(cm),
        .reg_kind(rk), .ext_int_sync(isync),
        .group_interrupt(gi), .gim_sel(gsel), .cpu_data(cpu_data),
        .cpu_ready(cpu_ready), .check_out(cko));
    rgiu_gim_model u_gim (.clk(clk), .rst(rst), .raise(raise),
        .sel(gsel), .gacc(gacc), .pat(pat), .int_line(gim_int),
        .data(gim_data));
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // check word for a register access kind: normal one, double more
    function automatic logic [15:0] exp_kind(input int i);
        exp_kind = (i == 1) ? 16'h0002 : ((i == 2) ? 16'h0001 : 16'h0000);
    endfunction : exp_kind
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] m,
        input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk({8'h00, rdata & m}, {8'h00, e});
    endtask : rd
    // answer must come 3+k cycles after the taking edge; none never answers
    task automatic acc(input logic [2:0] a, input int k, input logic fwd);
        int n;
        logic [7:0] d;
        n = 0;
        d = 8'($random(seed));
        @(posedge clk);
        pat <= d;
        gacc <= '{req: 1'b1, rd: 1'b1, addr: a};
        while (cpu_ready !== 1'b1 && n < 480)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(n), 16'(3 + k));
        chk({8'h00, cpu_data}, fwd ? {8'h00, d} : 16'h0000);
        chk({13'h0, cko}, (k < 477) ? {13'h0, cm} : 16'h0000);
        chk({15'h0, gsel}, 16'h0001);
        @(posedge clk);
        gacc.req <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, cpu_ready}, 16'h0000);
    endtask : acc
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(2'h0, 8'hff, 8'h06);
        rd(2'h3, 8'hff, 8'h00);
        @(posedge clk);
        raise <= 1'b1;
        hl <= 3'($random(seed));
        repeat (2) @(posedge clk);
        #1;
        chk({12'h0, isync}, {12'h0, hl, 1'b0});
        @(posedge clk);
        #1;
        chk({12'h0, isync}, {12'h0, hl, 1'b1});
        repeat (8) @(posedge clk);
        #1;
        chk({15'h0, gi}, 16'h0000);
        jp <= 3'h1;
        in_ctl <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk({15'h0, gi}, 16'h0000);
        in_ctl <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({15'h0, gi}, 16'h0001);
        acc(3'h0, 0, 1'b1);
        raise <= 1'b0;
        chk({15'h0, gi}, 16'h0000);
        acc(3'h1, 0, 1'b1);
        rd(2'h2, 8'h03, 8'h01);
        rd(2'h1, 8'h01, 8'h00);
        subst <= 1'b1;
        acc(3'h2, 150, 1'b1);
        acc(3'h3, 150, 1'b1);
        rd(2'h2, 8'h03, 8'h03);
        subst <= 1'b0;
        acc(3'h5, 300, 1'b0);
        acc(3'h4, 300, 1'b0);
        rd(2'h2, 8'h03, 8'h02);
        acc(3'h6, 477, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            rk <= rgiu_pkg::rgiu_regk_t'(i);
            @(posedge clk);
            #1;
            chk({13'h0, cko}, exp_kind(i));
        end
        rk <= rgiu_pkg::REGK_NONE;
        wr(2'h3, 8'h01);
        wr(2'h0, 8'h26);
        cm <= 3'b100;
        acc(3'h1, 450, 1'b0);
        repeat (2700) @(posedge clk);
        rd(2'h1, 8'h01, 8'h01);
        wr(2'h0, 8'h07);
        rd(2'h1, 8'h21, 8'h20);
        complete_run();
    end
endmodule : tb_redundant_group_interrupt_unit
